// file: core/mac_media_issue_latency.sv
// issue and result latency interlock model for clip, media, sad and multiply groups
//
// Contract
// - clip add/subtract: one issue, latency two
// - doubled clip: first operand needed early
// - media ops single issue, latency one/two
// - rearranging media ops need second operand early
// - sad ops: one issue, early sources, latency three
// - sad into following acc: one less latency
// - independent instructions issue during sad latency
// - three-stage multiplier, forwarding only to accumulate
// - long products: low word one cycle first
// - multiply sources are early-needed
// - product ops: 2 or 5 issue, latency 4
// - long products: 3 or 6, latency 4/5
// - halfword/dual products: one issue, latency three
// - long halfword, top word, double-acc timings
// - early operand needs one more cycle
`timescale 1ns/1ps
`default_nettype none

module mac_media_issue_latency #(
  parameter int NUM_REGS = mac_media_issue_pkg::NUM_REGS_DEF
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire mac_media_issue_pkg::issue_req_s req,
  output logic req_ready,
  output logic issued_valid,
  output mac_media_issue_pkg::issue_info_s issued,
  output logic interlock
);

  // refuse register counts that the index cannot reach
  if (NUM_REGS < 1 || NUM_REGS > (1 << mac_media_issue_pkg::REG_IDX_W)) begin : g_bad_regs
    $error("NUM_REGS out of range for register index width");
  end

  localparam int W = mac_media_issue_pkg::CNT_W;

  // decoded timing of the offered instruction
  logic [W-1:0] dec_issue;       // issue cycles
  logic [W-1:0] dec_lat_lo;      // latency of low / only word
  logic [W-1:0] dec_lat_hi;      // latency of high word
  logic dec_two_words;           // writes a 64-bit result
  mac_media_issue_pkg::result_stage_e dec_stage;
  logic early_first;             // first operand used in pre_alu_stage
  logic early_second;            // second operand used early
  logic early_third;             // third operand used early
  logic late_first;              // first operand needed a cycle late
  logic late_lo;                 // low accumulator word needed late
  logic late_hi;                 // high accumulator word needed late
  logic reads_lo;                // reads dst_lo as accumulator
  logic reads_hi;                // reads dst_hi as accumulator
  logic acc_first;               // first operand is the accumulator
  mac_media_issue_pkg::acc_fam_e dec_prod_fam;  // family of result produced
  mac_media_issue_pkg::acc_fam_e dec_cons_fam;  // family of accumulator consumed

  // scoreboard: cycles until each register is ready for an early use
  logic [W-1:0] avail_q [NUM_REGS];
  mac_media_issue_pkg::acc_fam_e fam_q [NUM_REGS];
  // remaining issue cycles of a multi-cycle instruction
  logic [W-1:0] busy_q;
  logic fire;

  // class decode into issue count, latencies and operand timing
  always_comb
  begin
    dec_issue = mac_media_issue_pkg::ISSUE_ONE;
    dec_lat_lo = mac_media_issue_pkg::LAT_ONE;
    dec_lat_hi = mac_media_issue_pkg::LAT_ONE;
    dec_two_words = 1'b0;
    dec_stage = mac_media_issue_pkg::STAGE_ALU;
    early_first = 1'b0;
    early_second = 1'b0;
    early_third = 1'b0;
    late_first = 1'b0;
    late_lo = 1'b0;
    late_hi = 1'b0;
    reads_lo = 1'b0;
    reads_hi = 1'b0;
    acc_first = 1'b0;
    dec_prod_fam = mac_media_issue_pkg::FAM_NONE;
    dec_cons_fam = mac_media_issue_pkg::FAM_NONE;
    case (req.op)
      // plain single cycle alu work
      mac_media_issue_pkg::OP_ALU:
      begin
        dec_lat_lo = mac_media_issue_pkg::LAT_ONE;
      end
      // saturating add/sub formed in the saturation stage
      mac_media_issue_pkg::OP_CLIP:
      begin
        dec_lat_lo = mac_media_issue_pkg::LAT_TWO;
        dec_stage = mac_media_issue_pkg::STAGE_SAT;
      end
      // doubling happens ahead of the alu
      mac_media_issue_pkg::OP_DCLIP:
      begin
        dec_lat_lo = mac_media_issue_pkg::LAT_TWO;
        dec_stage = mac_media_issue_pkg::STAGE_SAT;
        early_first = 1'b1;
      end
      // packed results out of the alu
      mac_media_issue_pkg::OP_MEDIA_ALU:
      begin
        dec_lat_lo = mac_media_issue_pkg::LAT_ONE;
      end
      // packed results out of the saturation stage
      mac_media_issue_pkg::OP_MEDIA_SAT:
      begin
        dec_lat_lo = mac_media_issue_pkg::LAT_TWO;
        dec_stage = mac_media_issue_pkg::STAGE_SAT;
      end
      // second operand rearranged before the alu
      mac_media_issue_pkg::OP_MEDIA_XALU:
      begin
        dec_lat_lo = mac_media_issue_pkg::LAT_ONE;
        early_second = 1'b1;
      end
      // rearranged and saturated
      mac_media_issue_pkg::OP_MEDIA_XSAT:
      begin
        dec_lat_lo = mac_media_issue_pkg::LAT_TWO;
        dec_stage = mac_media_issue_pkg::STAGE_SAT;
        early_second = 1'b1;
      end
      // sum of absolute differences
      mac_media_issue_pkg::OP_SAD, mac_media_issue_pkg::OP_SAD_ACC:
      begin
        dec_lat_lo = mac_media_issue_pkg::LAT_THREE;
        dec_stage = mac_media_issue_pkg::STAGE_SAD;
        early_second = 1'b1;
        early_third = 1'b1;
        dec_prod_fam = mac_media_issue_pkg::FAM_SAD;
        if (req.op == mac_media_issue_pkg::OP_SAD_ACC)
        begin
          acc_first = 1'b1;
          dec_cons_fam = mac_media_issue_pkg::FAM_SAD;
        end
      end
      // 32-bit products, optional addend on the first operand
      mac_media_issue_pkg::OP_PROD, mac_media_issue_pkg::OP_PROD_ACC:
      begin
        dec_issue = mac_media_issue_pkg::ISSUE_TWO;
        dec_lat_lo = mac_media_issue_pkg::LAT_FOUR;
        if (req.op == mac_media_issue_pkg::OP_PROD_ACC)
        begin
          late_first = 1'b1;
          acc_first = 1'b1;
        end
      end
      // 64-bit products
      mac_media_issue_pkg::OP_LMUL, mac_media_issue_pkg::OP_LMLA:
      begin
        dec_issue = mac_media_issue_pkg::ISSUE_THREE;
        dec_lat_lo = mac_media_issue_pkg::LAT_FOUR;
        dec_lat_hi = mac_media_issue_pkg::LAT_FIVE;
        dec_two_words = 1'b1;
        if (req.op == mac_media_issue_pkg::OP_LMLA)
        begin
          reads_lo = 1'b1;
          reads_hi = 1'b1;
          late_lo = 1'b1;
        end
      end
      // short products, single issue
      mac_media_issue_pkg::OP_HMUL, mac_media_issue_pkg::OP_HMLA:
      begin
        dec_lat_lo = mac_media_issue_pkg::LAT_THREE;
        acc_first = (req.op == mac_media_issue_pkg::OP_HMLA);
      end
      // long halfword / dual accumulate
      mac_media_issue_pkg::OP_LHMLA:
      begin
        dec_issue = mac_media_issue_pkg::ISSUE_TWO;
        dec_lat_lo = mac_media_issue_pkg::LAT_THREE;
        dec_lat_hi = mac_media_issue_pkg::LAT_FOUR;
        dec_two_words = 1'b1;
        reads_lo = 1'b1;
        reads_hi = 1'b1;
        late_hi = 1'b1;
      end
      // top word products
      mac_media_issue_pkg::OP_TOPMUL, mac_media_issue_pkg::OP_TOPMLA:
      begin
        dec_issue = mac_media_issue_pkg::ISSUE_TWO;
        dec_lat_lo = mac_media_issue_pkg::LAT_FOUR;
        if (req.op == mac_media_issue_pkg::OP_TOPMLA)
        begin
          late_first = 1'b1;
          acc_first = 1'b1;
        end
      end
      // unsigned double accumulate long
      mac_media_issue_pkg::OP_UDAAL:
      begin
        dec_issue = mac_media_issue_pkg::ISSUE_THREE;
        dec_lat_lo = mac_media_issue_pkg::LAT_FOUR;
        dec_lat_hi = mac_media_issue_pkg::LAT_FIVE;
        dec_two_words = 1'b1;
        reads_lo = 1'b1;
        reads_hi = 1'b1;
        late_lo = 1'b1;
      end
      default:
      begin
        dec_lat_lo = mac_media_issue_pkg::LAT_ONE;
      end
    endcase
    // every multiplier class shares the product stage and early sources
    if (req.op >= mac_media_issue_pkg::OP_PROD)
    begin
      dec_stage = mac_media_issue_pkg::STAGE_PRODUCT;
      early_second = 1'b1;
      early_third = 1'b1;
      dec_prod_fam = mac_media_issue_pkg::FAM_PROD;
      if (acc_first || reads_lo)
      begin
        dec_cons_fam = mac_media_issue_pkg::FAM_PROD;
      end
    end
    // flag-updating long-running products hold issue longer
    if (req.sets_flags && req.op >= mac_media_issue_pkg::OP_PROD && req.op <= mac_media_issue_pkg::OP_LMLA)
    begin
      dec_issue = dec_issue + mac_media_issue_pkg::FLAG_EXTRA;
    end
  end

  // readiness of one source register at a given threshold
  function automatic logic src_ok(
    input logic en,
    input logic [mac_media_issue_pkg::REG_IDX_W-1:0] idx,
    input logic early,
    input logic late,
    input logic acc,
    input mac_media_issue_pkg::acc_fam_e cons,
    input logic [W-1:0] cnt,
    input mac_media_issue_pkg::acc_fam_e fam
  );
    logic [W-1:0] thr;
    logic fwd;
    // accumulate path sees the result one cycle sooner
    fwd = acc && (cons != mac_media_issue_pkg::FAM_NONE) && (fam == cons);
    if (early)
    begin
      thr = mac_media_issue_pkg::THR_EARLY;
    end
    else
    begin
      thr = mac_media_issue_pkg::THR_NORMAL + W'(late) + W'(fwd);
    end
    // registers beyond the scoreboard are always ready
    src_ok = !en || (int'(idx) >= NUM_REGS) || (cnt <= thr);
  endfunction

  // counters of each source, zero when out of range
  logic [W-1:0] cnt_first, cnt_second, cnt_third, cnt_lo, cnt_hi;
  mac_media_issue_pkg::acc_fam_e fam_first, fam_lo, fam_hi;

  // scoreboard lookup of the offered sources
  always_comb
  begin
    cnt_first = mac_media_issue_pkg::CNT_ZERO;
    cnt_second = mac_media_issue_pkg::CNT_ZERO;
    cnt_third = mac_media_issue_pkg::CNT_ZERO;
    cnt_lo = mac_media_issue_pkg::CNT_ZERO;
    cnt_hi = mac_media_issue_pkg::CNT_ZERO;
    fam_first = mac_media_issue_pkg::FAM_NONE;
    fam_lo = mac_media_issue_pkg::FAM_NONE;
    fam_hi = mac_media_issue_pkg::FAM_NONE;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      if (req.first_operand == mac_media_issue_pkg::REG_IDX_W'(i))
      begin
        cnt_first = avail_q[i];
        fam_first = fam_q[i];
      end
      if (req.second_operand == mac_media_issue_pkg::REG_IDX_W'(i))
      begin
        cnt_second = avail_q[i];
      end
      if (req.third_operand == mac_media_issue_pkg::REG_IDX_W'(i))
      begin
        cnt_third = avail_q[i];
      end
      if (req.dst_lo == mac_media_issue_pkg::REG_IDX_W'(i))
      begin
        cnt_lo = avail_q[i];
        fam_lo = fam_q[i];
      end
      if (req.dst_hi == mac_media_issue_pkg::REG_IDX_W'(i))
      begin
        cnt_hi = avail_q[i];
        fam_hi = fam_q[i];
      end
    end
  end

  // issue only when no multi-cycle issue is under way and all sources are ready;
  // unrelated registers never stall, so independent work fills latency gaps
  always_comb
  begin
    req_ready = (busy_q == mac_media_issue_pkg::CNT_ZERO)
      && src_ok(req.first_en, req.first_operand, early_first, late_first, acc_first, dec_cons_fam,
                cnt_first, fam_first)
      && src_ok(req.second_en, req.second_operand, early_second, 1'b0, 1'b0, dec_cons_fam,
                cnt_second, mac_media_issue_pkg::FAM_NONE)
      && src_ok(req.third_en, req.third_operand, early_third, 1'b0, 1'b0, dec_cons_fam,
                cnt_third, mac_media_issue_pkg::FAM_NONE)
      && src_ok(reads_lo, req.dst_lo, 1'b0, late_lo, 1'b1, dec_cons_fam, cnt_lo, fam_lo)
      && src_ok(reads_hi, req.dst_hi, 1'b0, late_hi, 1'b1, dec_cons_fam, cnt_hi, fam_hi);
    fire = req_valid && req_ready;
  end

  // scoreboard: load latency on issue, count down otherwise
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        avail_q[i] <= mac_media_issue_pkg::CNT_ZERO;
        fam_q[i] <= mac_media_issue_pkg::FAM_NONE;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        if (fire && req.dst_lo_en && req.dst_lo == mac_media_issue_pkg::REG_IDX_W'(i))
        begin
          // low word, or the only word
          avail_q[i] <= dec_lat_lo;
          fam_q[i] <= dec_prod_fam;
        end
        else if (fire && dec_two_words && req.dst_hi_en && req.dst_hi == mac_media_issue_pkg::REG_IDX_W'(i))
        begin
          // high word lands one cycle after the low word
          avail_q[i] <= dec_lat_hi;
          fam_q[i] <= dec_prod_fam;
        end
        else if (avail_q[i] != mac_media_issue_pkg::CNT_ZERO)
        begin
          avail_q[i] <= avail_q[i] - mac_media_issue_pkg::CNT_STEP;
        end
      end
    end
  end

  // hold issue for the extra cycles of a multi-cycle instruction
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_q <= mac_media_issue_pkg::CNT_ZERO;
    end
    else if (fire)
    begin
      busy_q <= dec_issue - mac_media_issue_pkg::CNT_STEP;
    end
    else if (busy_q != mac_media_issue_pkg::CNT_ZERO)
    begin
      busy_q <= busy_q - mac_media_issue_pkg::CNT_STEP;
    end
  end

  // registered report of each issue and of stalls
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      issued_valid <= 1'b0;
      issued <= '0;
      interlock <= 1'b0;
    end
    else
    begin
      issued_valid <= fire;
      interlock <= req_valid && !req_ready;
      if (fire)
      begin
        issued.op <= req.op;
        issued.stage <= dec_stage;
        issued.issue_cycles <= dec_issue;
        issued.lat_lo <= dec_lat_lo;
        issued.lat_hi <= dec_two_words ? dec_lat_hi : dec_lat_lo;
        issued.two_words <= dec_two_words;
      end
    end
  end

endmodule

`default_nettype wire

// file: include/mac_media_issue_pkg.sv
// constants, classes and carriers shared by the issue timing model
`default_nettype none
package mac_media_issue_pkg;

  // register file index width and default register count
  localparam int REG_IDX_W = 4;
  localparam int NUM_REGS_DEF = 16;
  // width of availability counters, thresholds and issue counts
  localparam int CNT_W = 3;

  // result latencies in cycles
  localparam logic [CNT_W-1:0] LAT_ONE = 3'h1;
  localparam logic [CNT_W-1:0] LAT_TWO = 3'h2;
  localparam logic [CNT_W-1:0] LAT_THREE = 3'h3;
  localparam logic [CNT_W-1:0] LAT_FOUR = 3'h4;
  localparam logic [CNT_W-1:0] LAT_FIVE = 3'h5;

  // issue cycle counts
  localparam logic [CNT_W-1:0] ISSUE_ONE = 3'h1;
  localparam logic [CNT_W-1:0] ISSUE_TWO = 3'h2;
  localparam logic [CNT_W-1:0] ISSUE_THREE = 3'h3;
  // extra issue cycles when a long-running multiply updates flags
  localparam logic [CNT_W-1:0] FLAG_EXTRA = 3'h3;

  // operand readiness thresholds against the availability counter
  localparam logic [CNT_W-1:0] THR_EARLY = 3'h0;
  localparam logic [CNT_W-1:0] THR_NORMAL = 3'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_STEP = 3'h1;

  // instruction timing classes
  typedef enum logic [4:0] {
    OP_ALU,         // plain data processing
    OP_CLIP,        // clip_add_op, clip_subtract_op
    OP_DCLIP,       // doubled_clip_add_op, doubled_clip_subtract_op
    OP_MEDIA_ALU,   // packed add/sub, select
    OP_MEDIA_SAT,   // packed saturating / halving
    OP_MEDIA_XALU,  // cross add-sub, extend, unpack, byte_order_flip_op, halfword_pack_op
    OP_MEDIA_XSAT,  // signed_clip_to_width_op, cross saturating / halving
    OP_SAD,         // abs_diff_sum_op
    OP_SAD_ACC,     // abs_diff_sum_acc_op
    OP_PROD,        // product_op
    OP_PROD_ACC,    // product_acc_op
    OP_LMUL,        // signed/unsigned_long_product_op
    OP_LMLA,        // signed/unsigned_long_product_acc_op
    OP_HMUL,        // halfword, word-by-halfword, dual products
    OP_HMLA,        // accumulating halfword / dual products
    OP_LHMLA,       // long halfword and dual_long_product_acc_op
    OP_TOPMUL,      // top_word_product_op
    OP_TOPMLA,      // accumulating top word products
    OP_UDAAL        // unsigned_double_acc_long_op
  } op_class_e;

  // producer / consumer families of the accumulate forwarding paths
  typedef enum logic [1:0] {
    FAM_NONE,
    FAM_SAD,
    FAM_PROD
  } acc_fam_e;

  // pipeline stage that forms the result
  typedef enum logic [1:0] {
    STAGE_ALU,
    STAGE_SAT,
    STAGE_SAD,
    STAGE_PRODUCT
  } result_stage_e;

  // one instruction offered for issue
  typedef struct packed {
    op_class_e op;
    logic sets_flags;
    logic [REG_IDX_W-1:0] first_operand;
    logic first_en;
    logic [REG_IDX_W-1:0] second_operand;
    logic second_en;
    logic [REG_IDX_W-1:0] third_operand;
    logic third_en;
    logic [REG_IDX_W-1:0] dst_lo;
    logic dst_lo_en;
    logic [REG_IDX_W-1:0] dst_hi;
    logic dst_hi_en;
  } issue_req_s;

  // timing report of an issued instruction
  typedef struct packed {
    op_class_e op;
    result_stage_e stage;
    logic [CNT_W-1:0] issue_cycles;
    logic [CNT_W-1:0] lat_lo;
    logic [CNT_W-1:0] lat_hi;
    logic two_words;
  } issue_info_s;

endpackage
`default_nettype wire

// file: sim/mac_media_issue_checker.sv
// port-level assertions for the issue timing model
`timescale 1ns/1ps
`default_nettype none

module mac_media_issue_checker #(
  parameter int NUM_REGS = mac_media_issue_pkg::NUM_REGS_DEF
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire mac_media_issue_pkg::issue_req_s req,
  input wire logic req_ready,
  input wire logic issued_valid,
  input wire mac_media_issue_pkg::issue_info_s issued,
  input wire logic interlock
);
  // request accepted this cycle
  logic fire;
  // class of the offered request
  mac_media_issue_pkg::op_class_e op;

  assign fire = req_valid && req_ready;
  assign op = req.op;

  issue_report_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    fire |=> issued_valid && issued.op == $past(op))
    else $error("issue report missing or wrong class");
  clip_timing_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    fire && (op == mac_media_issue_pkg::OP_CLIP || op == mac_media_issue_pkg::OP_DCLIP) |=>
    issued.stage == mac_media_issue_pkg::STAGE_SAT && issued.lat_lo == 3'h2 && issued.issue_cycles == 3'h1)
    else $error("clip timing wrong");
  media_alu_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    fire && (op == mac_media_issue_pkg::OP_MEDIA_ALU || op == mac_media_issue_pkg::OP_MEDIA_XALU) |=>
    issued.lat_lo == 3'h1 && issued.issue_cycles == 3'h1)
    else $error("media alu timing wrong");
  sad_timing_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    fire && (op == mac_media_issue_pkg::OP_SAD || op == mac_media_issue_pkg::OP_SAD_ACC) |=>
    issued.lat_lo == 3'h3 && issued.issue_cycles == 3'h1)
    else $error("sad timing wrong");
  product_busy_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    fire && req.sets_flags && (op == mac_media_issue_pkg::OP_PROD || op == mac_media_issue_pkg::OP_PROD_ACC) |=>
    (!req_ready && issued.issue_cycles == 3'h5)[*4])
    else $error("flag product busy span wrong");
  long_product_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    fire && !req.sets_flags && op == mac_media_issue_pkg::OP_LMUL |=>
    issued.two_words && issued.lat_lo == 3'h4 && issued.lat_hi == 3'h5 && !req_ready ##1 !req_ready)
    else $error("long product timing wrong");
  half_product_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    fire && (op == mac_media_issue_pkg::OP_HMUL || op == mac_media_issue_pkg::OP_HMLA) |=>
    issued.issue_cycles == 3'h1 && issued.lat_lo == 3'h3 && issued.lat_hi == 3'h3)
    else $error("halfword product timing wrong");
  long_half_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    fire && op == mac_media_issue_pkg::OP_LHMLA |=>
    issued.issue_cycles == 3'h2 && issued.lat_lo == 3'h3 && issued.lat_hi == 3'h4)
    else $error("long halfword timing wrong");
  stall_flag_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    req_valid && !req_ready |=> interlock)
    else $error("stall not flagged");
  stall_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(req_valid && !req_ready) |=> !interlock)
    else $error("stall flagged without cause");
endmodule

bind mac_media_issue_latency mac_media_issue_checker #(.NUM_REGS(NUM_REGS)) u_checker (
  .ref_clk(ref_clk), .rstn(rstn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
  .issued_valid(issued_valid), .issued(issued), .interlock(interlock));
`default_nettype wire

// file: sim/test_mac_media_issue_latency.sv
// self-checking bench for the issue timing model
`timescale 1ns/1ps
`default_nettype none

module test_mac_media_issue_latency;
  // producer class, consumer class, operand slot, expected fire gap
  typedef struct {int p; int c; int f; int g;} dep_s;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  mac_media_issue_pkg::issue_req_s req = '0;
  logic req_ready;
  logic issued_valid;
  mac_media_issue_pkg::issue_info_s issued;
  logic interlock;
  int miscompares = 0;
  int samples_checked = 0;
  // expected reports, oldest first
  mac_media_issue_pkg::issue_info_s expq[$];
  mac_media_issue_pkg::issue_info_s e;
  logic [31:0] seed = 32'h27;
  int t0, t1, t2, t3, c, pc;
  logic f, pf;
  logic [3:0] r;
  // per-class issue cycles, low and high latency, stage
  int iss_t[19] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 2, 2, 3, 3, 1, 1, 2, 2, 2, 3};
  int lo_t[19] = '{1, 2, 2, 1, 2, 1, 2, 3, 3, 4, 4, 4, 4, 3, 3, 3, 4, 4, 4};
  int hi_t[19] = '{1, 2, 2, 1, 2, 1, 2, 3, 3, 4, 4, 5, 5, 3, 3, 4, 4, 4, 5};
  int stg_t[19] = '{0, 1, 1, 0, 1, 0, 1, 2, 2, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3};
  // dependent pairs; slot 5 reads the high result word
  dep_s deps[18] = '{
    '{7, 0, 0, 3}, '{7, 8, 0, 2}, '{7, 7, 1, 4},
    '{1, 0, 0, 2}, '{1, 2, 0, 3},
    '{3, 0, 0, 1}, '{3, 5, 1, 2}, '{4, 6, 1, 3},
    '{9, 0, 0, 4}, '{9, 9, 2, 5}, '{9, 10, 0, 2},
    '{13, 0, 0, 3}, '{13, 14, 0, 2},
    '{11, 0, 0, 4}, '{11, 0, 5, 5},
    '{15, 0, 5, 4}, '{18, 0, 5, 5}, '{16, 0, 0, 4}
  };

  // free-running core clock
  always #5 ref_clk = ~ref_clk;

  mac_media_issue_latency #(.NUM_REGS(16)) u_mac_media_issue_latency (
    .ref_clk(ref_clk), .rstn(rstn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .issued_valid(issued_valid), .issued(issued), .interlock(interlock));

  // xorshift step for stimulus values
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // expected issue report of a class
  function automatic mac_media_issue_pkg::issue_info_s exp_info(input int k, input logic fl);
    mac_media_issue_pkg::issue_info_s x;
    x.op = mac_media_issue_pkg::op_class_e'(k);
    x.stage = mac_media_issue_pkg::result_stage_e'(stg_t[k]);
    x.issue_cycles = 3'(iss_t[k] + ((fl && k >= 9 && k <= 12) ? 3 : 0));
    x.lat_lo = 3'(lo_t[k]);
    x.lat_hi = 3'(hi_t[k]);
    x.two_words = hi_t[k] != lo_t[k];
    return x;
  endfunction

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // offer one request, hold until taken, return fire cycle
  task automatic send(input int k, input logic fl, input logic [3:0] s, input logic [2:0] en,
                      input logic [3:0] d, output int t);
    logic rdy;
    int n;
    n = 0;
    req.op = mac_media_issue_pkg::op_class_e'(k);
    req.sets_flags = fl;
    req.first_operand = s;
    req.second_operand = s;
    req.third_operand = s;
    {req.first_en, req.second_en, req.third_en} = en;
    req.dst_lo = d;
    req.dst_hi = d + 4'h1;
    req.dst_lo_en = 1'b1;
    req.dst_hi_en = 1'b1;
    req_valid = 1'b1;
    do
    begin
      @(negedge ref_clk);
      rdy = req_ready;
      @(posedge ref_clk);
      n++;
    end
    while (rdy !== 1'b1 && n < 40);
    if (rdy !== 1'b1)
      check(32'h0, 32'h1);
    t = int'($time / 10);
    expq.push_back(exp_info(k, fl));
    #1;
  endtask

  // drop the request and let every result drain
  task automatic idle();
    req_valid = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  // print counts and verdict, end the run
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // report watcher against the oldest expectation
  always @(negedge ref_clk)
  begin
    if (issued_valid === 1'b1)
      check(32'(issued), expq.size() > 0 ? 32'(expq.pop_front()) : 32'hFFFFFFFF);
  end

  // hang guard
  initial
  begin
    #100000;
    miscompares++;
    conclude();
  end

  // main sequence
  initial
  begin
    repeat (5) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    check(32'({req_ready, issued_valid, interlock}), 32'h4);
    // every class twice, then random classes, no sources
    for (int i = 0; i < 78; i++)
    begin
      seed = xs(seed);
      c = (i < 38) ? i % 19 : int'(seed % 19);
      f = (i < 38) ? (i >= 19) : seed[8];
      // rotating even destinations: a register is reused only after eight issues,
      // so accumulating classes never wait on an earlier result here
      send(c, f, 4'h0, 3'h0, 4'(2 * (i % 8)), t1);
      e = exp_info(pc, pf);
      if (i > 0)
        check(32'(t1 - t0), 32'(e.issue_cycles));
      t0 = t1;
      pc = c;
      pf = f;
    end
    // dependent pairs through the scoreboard
    foreach (deps[k])
    begin
      idle();
      seed = xs(seed);
      r = 4'h2 + 4'(seed % 12);
      send(deps[k].p, 1'b0, 4'h0, 3'h0, r, t0);
      send(deps[k].c, 1'b0, (deps[k].f == 5) ? r + 4'h1 : r, 3'h4 >> (deps[k].f % 5), 4'h0, t1);
      check(32'(t1 - t0), 32'(deps[k].g));
    end
    // independent work inside the sad latency
    idle();
    send(7, 1'b0, 4'h0, 3'h0, 4'h5, t0);
    send(0, 1'b0, 4'h0, 3'h0, 4'h9, t1);
    send(0, 1'b0, 4'h0, 3'h0, 4'h9, t2);
    send(0, 1'b0, 4'h5, 3'h4, 4'h9, t3);
    check(32'(t2 - t0), 32'h2);
    check(32'(t3 - t0), 32'h3);
    idle();
    check(32'(expq.size()), 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
